//--- verilog/dpvc_defs.vh
`ifndef DPVC_DEFS_VH
`define DPVC_DEFS_VH

// register offsets, page 0
`define DPVC_ADDR_RSVD_A_LO 8'h37
`define DPVC_ADDR_RSVD_A_HI 8'h3B
`define DPVC_ADDR_PB_SEL 8'h3C
`define DPVC_ADDR_REC_SEL 8'h3D
`define DPVC_ADDR_RSVD_B 8'h3E
`define DPVC_ADDR_PATH 8'h3F
`define DPVC_ADDR_VOLCTL 8'h40

// reset values
`define DPVC_RST_PB_SEL 8'h01
`define DPVC_RST_REC_SEL 8'h04
`define DPVC_RST_RSVD_B 8'h00
`define DPVC_RST_PATH 8'h14
`define DPVC_RST_VOLCTL 8'h0C
`define DPVC_RST_GAIN 8'h00
`define DPVC_RD_RSVD 8'h00
`define DPVC_RST_RDATA 8'h00
`define DPVC_RST_VALID 1'h1

// field positions
`define DPVC_SEL_HI 4
`define DPVC_SEL_LO 0
`define DPVC_PATH_LPWR 7
`define DPVC_PATH_RPWR 6
`define DPVC_PATH_LROUTE_HI 5
`define DPVC_PATH_LROUTE_LO 4
`define DPVC_PATH_RROUTE_HI 3
`define DPVC_PATH_RROUTE_LO 2
`define DPVC_PATH_STEP_HI 1
`define DPVC_PATH_STEP_LO 0
`define DPVC_VOL_LMUTE 3
`define DPVC_VOL_RMUTE 2
`define DPVC_VOL_COUPLE_HI 1
`define DPVC_VOL_COUPLE_LO 0

// playback block code range
`define DPVC_PB_MIN 5'h01
`define DPVC_PB_MAX 5'h19

// routing codes, own means the channel's own side
`define DPVC_ROUTE_OFF 2'h0
`define DPVC_ROUTE_OWN 2'h1
`define DPVC_ROUTE_OTHER 2'h2
`define DPVC_ROUTE_AVG 2'h3

// soft-step codes
`define DPVC_STEP_ONE 2'h0
`define DPVC_STEP_TWO 2'h1
`define DPVC_STEP_NONE 2'h2

// coupling codes
`define DPVC_COUPLE_INDEP 2'h0
`define DPVC_COUPLE_L_FROM_R 2'h1
`define DPVC_COUPLE_R_FROM_L 2'h2

// gain code limits, signed 0.5 dB steps
`define DPVC_GAIN_MAX 8'h30
`define DPVC_GAIN_MIN 8'h81
`define DPVC_GAIN_BAD 8'h80

`endif

//--- verilog/dpvc_route.v
`timescale 1ns/1ps
`default_nettype none
`include "dpvc_defs.vh"

module dpvc_route (
    // selection
    input wire [1:0] route_i,
    // samples, own side and opposite side
    input wire [15:0] own_i,
    input wire [15:0] other_i,
    // routed sample
    output reg [15:0] data_o
);

    wire [16:0] sum;

    // sign-extended sum so the average never overflows
    assign sum = {own_i[15], own_i} + {other_i[15], other_i};

    // source select for one dac channel
    always @* begin
        case (route_i)
            `DPVC_ROUTE_OFF: data_o = 16'h0000;
            `DPVC_ROUTE_OWN: data_o = own_i;
            `DPVC_ROUTE_OTHER: data_o = other_i;
            default: data_o = sum[16:1]; // (l + r) / 2
        endcase
    end

endmodule // dpvc_route
`default_nettype wire

//--- verilog/dpvc_vol_ramp.v
`timescale 1ns/1ps
`default_nettype none
`include "dpvc_defs.vh"

module dpvc_vol_ramp (
    // clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // control
    input wire [7:0] target_i,
    input wire [1:0] step_mode_i,
    input wire sample_tick_i,
    // applied gain
    output wire [7:0] gain_o
);

    reg [7:0] gain_ff;
    reg half_ff;
    wire step_now;
    wire ramping;
    wire go_up;

    assign ramping = (step_mode_i == `DPVC_STEP_ONE) ||
                     (step_mode_i == `DPVC_STEP_TWO);
    // every tick, or every second tick
    assign step_now = sample_tick_i &&
                      ((step_mode_i == `DPVC_STEP_ONE) || half_ff);
    assign go_up = $signed(target_i) > $signed(gain_ff);
    assign gain_o = gain_ff;

    // one 0.5 dB step per selected sample period, else jump
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gain_ff <= `DPVC_RST_GAIN;
            half_ff <= 1'b0;
        end else begin
            if (sample_tick_i) begin
                half_ff <= ~half_ff;
            end
            if (!ramping) begin
                gain_ff <= target_i;
            end else if (step_now && (gain_ff != target_i)) begin
                gain_ff <= go_up ? gain_ff + 8'h01 :
                           gain_ff - 8'h01;
            end
        end
    end

endmodule // dpvc_vol_ramp
`default_nettype wire

//--- verilog/dpvc_top.v
// Operation
// - playback select 5 bits, reset 1, 1..25
// - record select reset 4, listed codes valid
// - path bit 7 powers left dac
// - path bit 6 powers right dac
// - left routing: off, left, right, average
// - right routing: off, right, left, average
// - soft-step: per sample, per two, immediate
// - volume bit 3 mutes left, reset muted
// - volume bit 2 mutes right, reset muted
// - coupling copies one channel's volume
// - compression active forces independent volumes
// - gain codes 0x81..0x30, half dB steps
`timescale 1ns/1ps
`default_nettype none
`include "dpvc_defs.vh"

module dpvc_top (
    // clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // register port behind the control bus engine
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [7:0] reg_rdata_o,
    // playback datapath inputs
    input wire sample_tick_i,
    input wire [15:0] left_data_i,
    input wire [15:0] right_data_i,
    input wire [7:0] left_vol_i,
    input wire [7:0] right_vol_i,
    input wire drc_active_i,
    // block selection outputs
    output wire [4:0] playback_block_o,
    output wire playback_block_valid_o,
    output wire [4:0] record_block_o,
    output wire record_block_valid_o,
    // dac channel outputs
    output wire left_power_o,
    output wire right_power_o,
    output wire left_mute_o,
    output wire right_mute_o,
    output wire [15:0] left_dac_data_o,
    output wire [15:0] right_dac_data_o,
    output wire [7:0] left_gain_o,
    output wire [7:0] right_gain_o
);

    // checks a record block code against the supported set
    function rec_code_ok;
        input [4:0] code;
        begin
            case (code)
                5'h04, 5'h05, 5'h06,
                5'h0A, 5'h0B, 5'h0C,
                5'h10, 5'h11, 5'h12: rec_code_ok = 1'b1;
                default: rec_code_ok = 1'b0;
            endcase
        end
    endfunction

    // checks a playback block code against the supported range
    function pb_code_ok;
        input [4:0] code;
        begin
            pb_code_ok = (code >= `DPVC_PB_MIN) && (code <= `DPVC_PB_MAX);
        end
    endfunction

    // folds unused gain codes onto the nearest legal one
    function [7:0] gain_clamp;
        input [7:0] code;
        begin
            if (code == `DPVC_GAIN_BAD) begin
                gain_clamp = `DPVC_GAIN_MIN;
            end else if ($signed(code) > $signed(`DPVC_GAIN_MAX)) begin
                gain_clamp = `DPVC_GAIN_MAX;
            end else begin
                gain_clamp = code;
            end
        end
    endfunction

    // one-hot select of the stored register at an offset
    function [3:0] reg_hit;
        input [7:0] addr;
        begin
            case (addr)
                `DPVC_ADDR_PB_SEL: reg_hit = 4'h1;
                `DPVC_ADDR_REC_SEL: reg_hit = 4'h2;
                `DPVC_ADDR_PATH: reg_hit = 4'h4;
                `DPVC_ADDR_VOLCTL: reg_hit = 4'h8;
                default: reg_hit = 4'h0;
            endcase
        end
    endfunction

    // volume target of one channel after coupling and clamping
    function [7:0] chan_target;
        input copy;
        input [7:0] own_vol;
        input [7:0] other_vol;
        begin
            if (copy) begin
                chan_target = gain_clamp(other_vol);
            end else begin
                chan_target = gain_clamp(own_vol);
            end
        end
    endfunction

    // register storage
    reg [7:0] pb_sel_ff;
    reg [7:0] rec_sel_ff;
    reg [7:0] path_ff;
    reg [7:0] volctl_ff;
    reg [7:0] rdata_ff;
    reg [7:0] nxt_rdata;

    // derived outputs, registered
    reg pb_valid_ff;
    reg rec_valid_ff;
    reg [15:0] left_dac_ff;
    reg [15:0] right_dac_ff;

    // combinational helpers
    wire [1:0] step_mode;
    wire [1:0] couple;
    wire [1:0] eff_couple;
    wire [7:0] left_tgt;
    wire [7:0] right_tgt;
    wire [15:0] tgt_vec;
    wire [15:0] gain_vec;
    wire [3:0] route_vec;
    wire [31:0] own_vec;
    wire [31:0] other_vec;
    wire [31:0] routed_vec;
    wire left_on;
    wire right_on;
    wire [3:0] wr_hit;
    wire [3:0] rd_hit;

    // write decode, at most one register per strobe
    assign wr_hit = reg_wr_i ? reg_hit(reg_addr_i) : 4'h0;

    // read decode, same map as the writes
    assign rd_hit = reg_rd_i ? reg_hit(reg_addr_i) : 4'h0;

    // register writes; reserved areas keep no state
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pb_sel_ff <= `DPVC_RST_PB_SEL;
            rec_sel_ff <= `DPVC_RST_REC_SEL;
            path_ff <= `DPVC_RST_PATH;
            volctl_ff <= `DPVC_RST_VOLCTL;
        end else begin
            if (wr_hit[0]) begin
                pb_sel_ff <= reg_wdata_i;
            end
            if (wr_hit[1]) begin
                rec_sel_ff <= reg_wdata_i;
            end
            if (wr_hit[2]) begin
                path_ff <= reg_wdata_i;
            end
            if (wr_hit[3]) begin
                volctl_ff <= reg_wdata_i;
            end
        end
    end

    // read mux; reserved and unmapped offsets read zero
    always @* begin
        nxt_rdata = rdata_ff;
        if (rd_hit[0]) begin
            nxt_rdata = pb_sel_ff;
        end else if (rd_hit[1]) begin
            nxt_rdata = rec_sel_ff;
        end else if (rd_hit[2]) begin
            nxt_rdata = path_ff;
        end else if (rd_hit[3]) begin
            nxt_rdata = volctl_ff;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `DPVC_ADDR_RSVD_B) begin
                nxt_rdata = `DPVC_RST_RSVD_B;
            end else begin
                nxt_rdata = `DPVC_RD_RSVD;
            end
        end
    end

    // read data register holds until the next read
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= `DPVC_RST_RDATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // registered read data straight to the port
    assign reg_rdata_o = rdata_ff;

    // block selection fields and their validity
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pb_valid_ff <= `DPVC_RST_VALID;
            rec_valid_ff <= `DPVC_RST_VALID;
        end else begin
            pb_valid_ff <= pb_code_ok(
                pb_sel_ff[`DPVC_SEL_HI:`DPVC_SEL_LO]);
            rec_valid_ff <= rec_code_ok(
                rec_sel_ff[`DPVC_SEL_HI:`DPVC_SEL_LO]);
        end
    end

    // selected codes and their flags
    assign playback_block_o = pb_sel_ff[`DPVC_SEL_HI:`DPVC_SEL_LO];
    assign record_block_o = rec_sel_ff[`DPVC_SEL_HI:`DPVC_SEL_LO];
    assign playback_block_valid_o = pb_valid_ff;
    assign record_block_valid_o = rec_valid_ff;

    // power and mute straight from the register bits
    assign left_power_o = path_ff[`DPVC_PATH_LPWR];
    assign right_power_o = path_ff[`DPVC_PATH_RPWR];
    assign left_mute_o = volctl_ff[`DPVC_VOL_LMUTE];
    assign right_mute_o = volctl_ff[`DPVC_VOL_RMUTE];

    // volume coupling, overridden while compression runs
    assign couple = volctl_ff[`DPVC_VOL_COUPLE_HI:`DPVC_VOL_COUPLE_LO];
    assign eff_couple = drc_active_i ? `DPVC_COUPLE_INDEP :
                        couple;
    assign left_tgt = chan_target(eff_couple == `DPVC_COUPLE_L_FROM_R,
        left_vol_i, right_vol_i);
    assign right_tgt = chan_target(eff_couple == `DPVC_COUPLE_R_FROM_L,
        right_vol_i, left_vol_i);

    // soft-step rate shared by both ramps
    assign step_mode = path_ff[`DPVC_PATH_STEP_HI:`DPVC_PATH_STEP_LO];

    // channel 0 is left, channel 1 is right
    assign tgt_vec = {right_tgt, left_tgt};
    assign route_vec = {path_ff[`DPVC_PATH_RROUTE_HI:`DPVC_PATH_RROUTE_LO],
                        path_ff[`DPVC_PATH_LROUTE_HI:`DPVC_PATH_LROUTE_LO]};
    assign own_vec = {right_data_i, left_data_i};
    assign other_vec = {left_data_i, right_data_i};

    // per channel gain ramp and source routing
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            dpvc_vol_ramp u_ramp (
                .core_clk_i(core_clk_i),
                .resetn_i(resetn_i),
                .target_i(tgt_vec[ch*8 +: 8]),
                .step_mode_i(step_mode),
                .sample_tick_i(sample_tick_i),
                .gain_o(gain_vec[ch*8 +: 8])
            );
            dpvc_route u_route (
                .route_i(route_vec[ch*2 +: 2]),
                .own_i(own_vec[ch*16 +: 16]),
                .other_i(other_vec[ch*16 +: 16]),
                .data_o(routed_vec[ch*16 +: 16])
            );
        end
    endgenerate

    // applied gains from the ramp registers
    assign left_gain_o = gain_vec[7:0];
    assign right_gain_o = gain_vec[15:8];

    // a channel passes data only when powered and not muted
    assign left_on = path_ff[`DPVC_PATH_LPWR] &&
                     !volctl_ff[`DPVC_VOL_LMUTE];
    assign right_on = path_ff[`DPVC_PATH_RPWR] &&
                      !volctl_ff[`DPVC_VOL_RMUTE];

    // registered dac samples
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            left_dac_ff <= 16'h0000;
            right_dac_ff <= 16'h0000;
        end else begin
            left_dac_ff <= left_on ? routed_vec[15:0] : 16'h0000;
            right_dac_ff <= right_on ? routed_vec[31:16] :
                            16'h0000;
        end
    end

    // registered samples straight to the ports
    assign left_dac_data_o = left_dac_ff;
    assign right_dac_data_o = right_dac_ff;

endmodule // dpvc_top
`default_nettype wire

//--- verification/dpvc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dpvc_chk (
    // clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // register port
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    // watched outputs
    input wire [4:0] playback_block_o,
    input wire playback_block_valid_o,
    input wire [4:0] record_block_o,
    input wire record_block_valid_o,
    input wire left_power_o,
    input wire right_power_o,
    input wire left_mute_o,
    input wire right_mute_o,
    input wire [15:0] left_dac_data_o,
    input wire [7:0] left_gain_o
);
    // single domain, reset cancels every attempt
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // flags trail the select codes by one cycle
    a_pb_valid_range: assert property (
        playback_block_valid_o ==
        ($past(playback_block_o) inside {[5'h01:5'h19]}))
        else $error("playback valid flag wrong");
    a_rec_valid_set: assert property (
        record_block_valid_o == ($past(record_block_o) inside {5'h04,
        5'h05, 5'h06, 5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h11, 5'h12}))
        else $error("record valid flag wrong");
    // register fields take the written byte
    a_pb_sel_write: assert property (
        reg_wr_i && reg_addr_i == 8'h3C |=>
        {3'h0, playback_block_o} == ($past(reg_wdata_i) & 8'h1F))
        else $error("playback select not written");
    a_rec_sel_write: assert property (
        reg_wr_i && reg_addr_i == 8'h3D |=>
        {3'h0, record_block_o} == ($past(reg_wdata_i) & 8'h1F))
        else $error("record select not written");
    a_power_write: assert property (
        reg_wr_i && reg_addr_i == 8'h3F |=>
        {6'h00, left_power_o, right_power_o} == ($past(reg_wdata_i) >> 6))
        else $error("power bits not written");
    a_mute_write: assert property (
        reg_wr_i && reg_addr_i == 8'h40 |=> {6'h00, left_mute_o,
        right_mute_o} == (($past(reg_wdata_i) >> 2) & 8'h03))
        else $error("mute bits not written");
    // a silent left channel outputs zero
    a_dac_gated: assert property (
        !left_power_o || left_mute_o |=> left_dac_data_o == 16'h0000)
        else $error("left dac data not gated");
    // reserved places read zero
    a_rsvd_read_zero: assert property (
        reg_rd_i && (reg_addr_i inside {[8'h37:8'h3B]} ||
        reg_addr_i == 8'h3E) |=> reg_rdata_o == 8'h00)
        else $error("reserved read not zero");
    a_rdata_holds: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without read");
    a_gain_legal: assert property (
        !(left_gain_o inside {[8'h31:8'h80]}))
        else $error("unused gain code applied");
endmodule // dpvc_chk
bind dpvc_top dpvc_chk u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .playback_block_o(playback_block_o),
    .playback_block_valid_o(playback_block_valid_o),
    .record_block_o(record_block_o),
    .record_block_valid_o(record_block_valid_o),
    .left_power_o(left_power_o), .right_power_o(right_power_o),
    .left_mute_o(left_mute_o), .right_mute_o(right_mute_o),
    .left_dac_data_o(left_dac_data_o), .left_gain_o(left_gain_o));
`default_nettype wire

//--- verification/tb_dac_path_and_volume_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dac_path_and_volume_config;
    logic core_clk_i, resetn_i, reg_wr_i, reg_rd_i, sample_tick_i;
    logic drc_active_i, rd_seen;
    logic [7:0] reg_addr_i, reg_wdata_i, left_vol_i, right_vol_i;
    logic [15:0] left_data_i, right_data_i;
    logic [7:0] exp_q[$];
    wire [7:0] reg_rdata_o, left_gain_o, right_gain_o;
    wire [4:0] playback_block_o, record_block_o;
    wire playback_block_valid_o, record_block_valid_o;
    wire left_power_o, right_power_o, left_mute_o, right_mute_o;
    wire [15:0] left_dac_data_o, right_dac_data_o;
    int num_errors, n_tests, seed;
    dpvc_top dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .sample_tick_i(sample_tick_i), .left_data_i(left_data_i),
        .right_data_i(right_data_i), .left_vol_i(left_vol_i),
        .right_vol_i(right_vol_i), .drc_active_i(drc_active_i),
        .playback_block_o(playback_block_o),
        .playback_block_valid_o(playback_block_valid_o),
        .record_block_o(record_block_o),
        .record_block_valid_o(record_block_valid_o),
        .left_power_o(left_power_o), .right_power_o(right_power_o),
        .left_mute_o(left_mute_o), .right_mute_o(right_mute_o),
        .left_dac_data_o(left_dac_data_o),
        .right_dac_data_o(right_dac_data_o),
        .left_gain_o(left_gain_o), .right_gain_o(right_gain_o));
    // 100 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobe held for one taking edge, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        tick(1);
        reg_wr_i <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        tick(1);
        reg_rd_i <= 1'b0;
        tick(1);
    endtask
    task automatic pulse;
        sample_tick_i <= 1'b1;
        tick(1);
        sample_tick_i <= 1'b0;
        tick(2);
    endtask
    function automatic logic [15:0] route(input int k,
        input logic [15:0] o, input logic [15:0] t);
        logic [16:0] s;
        s = {o[15], o} + {t[15], t};
        return k == 0 ? 16'h0000 : k == 1 ? o : k == 2 ? t : s[16:1];
    endfunction
    // read data arrives the cycle after a taken read
    always @(posedge core_clk_i) begin
        if (rd_seen) begin
            chk(reg_rdata_o, exp_q.pop_front());
        end
        rd_seen <= reg_rd_i;
    end
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #500000;
        num_errors++;
        give_verdict;
    end
    initial begin
        logic [15:0] l, r;
        int k;
        {reg_wr_i, reg_rd_i, sample_tick_i, drc_active_i, rd_seen} = 5'h00;
        {reg_addr_i, reg_wdata_i, left_vol_i, right_vol_i} = 32'h0;
        {left_data_i, right_data_i} = 32'h0;
        resetn_i = 1'b0;
        seed = $urandom(98);
        tick(20);
        resetn_i <= 1'b1;
        tick(1);
        chk({playback_block_valid_o, record_block_valid_o, left_power_o,
            right_power_o, left_mute_o, right_mute_o}, 6'h33);
        chk(left_gain_o, 8'h00);
        rd(8'h3C, 8'h01);
        rd(8'h3D, 8'h04);
        rd(8'h3F, 8'h14);
        rd(8'h40, 8'h0C);
        for (k = 8'h37; k <= 8'h3E; k++) begin
            if (k == 8'h3E) begin
                wr(8'h3E, 8'h00);
            end
            if (k < 8'h3C || k == 8'h3E) begin
                rd(8'(k), 8'h00);
            end
        end
        for (k = 1; k < 26; k++) begin
            wr(8'h3C, 8'(k));
            tick(1);
            chk(playback_block_valid_o, k >= 1 && k <= 25);
            rd(8'h3C, 8'(k));
        end
        for (k = 1; k < 19; k++) begin
            wr(8'h3D, 8'(k));
            tick(1);
            chk(record_block_valid_o, k inside {4, 5, 6, 10, 11, 12, 16, 17,
                18});
        end
        wr(8'h40, 8'h00);
        for (k = 0; k < 4; k++) begin
            l = $urandom;
            r = $urandom;
            left_data_i <= l;
            right_data_i <= r;
            wr(8'h3F, 8'(8'hC2 | (k << 4) | (k << 2)));
            tick(2);
            chk(left_dac_data_o, route(k, l, r));
            chk(right_dac_data_o, route(k, r, l));
        end
        wr(8'h40, 8'h08);
        tick(2);
        chk(left_dac_data_o, 16'h0000);
        chk(right_dac_data_o, route(3, r, l));
        left_vol_i <= 8'h10;
        right_vol_i <= 8'hF0;
        for (k = 0; k < 8; k++) begin
            drc_active_i <= k[2];
            wr(8'h40, 8'(k[1:0]));
            tick(3);
            chk(left_gain_o, k == 1 ? 8'hF0 : 8'h10);
            chk(right_gain_o, k == 2 ? 8'h10 : 8'hF0);
        end
        drc_active_i <= 1'b0;
        left_vol_i <= 8'h7F;
        right_vol_i <= 8'h80;
        wr(8'h40, 8'h00);
        tick(3);
        chk(left_gain_o, 8'h30);
        chk(right_gain_o, 8'h81);
        left_vol_i <= 8'h00;
        tick(3);
        wr(8'h3F, 8'hFC);
        left_vol_i <= 8'h03;
        tick(2);
        chk(left_gain_o, 8'h00);
        for (k = 1; k < 5; k++) begin
            pulse;
            chk(left_gain_o, 8'(k > 3 ? 3 : k));
        end
        wr(8'h3F, 8'hFD);
        left_vol_i <= 8'h07;
        repeat (4) pulse;
        chk(left_gain_o, 8'h05);
        give_verdict;
    end
endmodule // tb_dac_path_and_volume_config
`default_nettype wire
